// *** swdrv_ctrl.sv ***
// Host controller that drives a latching multiport coaxial switch.
// Assumes drive and indicator pins are synchronous to CLK; pin polarity
// is converted inside through ACTIVE_HIGH (TTL) or left low-active.

// Overview of operation
// - Asserting one drive line closes that path; level set per variant.
// - Drive pulses last at least 15 ms, then are released.
// - Break-before-make: unwanted drive lines are released before a new path is driven.
// - Open-all: release every drive line first, then assert open-all.
// - Make-before-break drives old and new paths together.
// - After 15 ms both, only the old drive is released.
module swdrv_ctrl #(
  parameter int HOLD_CYCLES = swdrv_pkg::HOLD_CYC,
  parameter bit SIX_THROW = 1'b1,
  parameter bit HAS_OPEN_ALL = 1'b1,
  parameter bit ACTIVE_HIGH = 1'b0
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_PATH,
  input wire logic REQ_MBB,
  input wire logic REQ_OPEN_ALL,
  input wire logic [5:0] IND_CLOSED,
  output logic REQ_READY,
  output logic [5:0] DRIVE,
  output logic OPEN_ALL,
  output logic DONE,
  output logic FAULT,
  output logic [5:0] PATH_STATE
);

  localparam logic [5:0] VALID_MASK =
    SIX_THROW ? swdrv_pkg::SP6T_MASK : swdrv_pkg::SP4T_MASK;

  swdrv_pkg::state_t state;
  logic [31:0] timer;
  logic [5:0] cur_sel;
  logic [5:0] new_sel;
  logic [5:0] drive_act;
  logic open_act;
  logic [5:0] req_onehot;
  logic req_ok;

  function automatic logic [5:0] onehot(input logic [2:0] p);
    logic [5:0] r;
    r = 6'h00;
    if (p < 3'h6) begin
      r[p] = 1'b1;
    end
    return r;
  endfunction

  assign req_onehot = onehot(REQ_PATH) & VALID_MASK;
  assign req_ok = REQ_OPEN_ALL ? HAS_OPEN_ALL : (req_onehot != 6'h00);

  // ********************************************************
  // Sequencer
  // ********************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= swdrv_pkg::ST_IDLE;
      timer <= 32'h0;
      cur_sel <= 6'h00;
      new_sel <= 6'h00;
      drive_act <= 6'h00;
      open_act <= 1'b0;
    end else begin
      case (state)
        swdrv_pkg::ST_IDLE: begin
          timer <= 32'h0;
          if (REQ_VALID && req_ok) begin
            if (REQ_OPEN_ALL) begin
              drive_act <= 6'h00;
              state <= swdrv_pkg::ST_OPEN_GAP;
            end else if (REQ_MBB && cur_sel != 6'h00) begin
              new_sel <= req_onehot;
              drive_act <= cur_sel | req_onehot;
              state <= swdrv_pkg::ST_MBB_BOTH;
            end else begin
              // Release first so two paths never engage
              new_sel <= req_onehot;
              drive_act <= 6'h00;
              state <= swdrv_pkg::ST_BREAK;
            end
          end
        end
        swdrv_pkg::ST_BREAK: begin
          if (timer >= 32'(swdrv_pkg::SETTLE_CYC - 1)) begin
            timer <= 32'h0;
            drive_act <= new_sel;
            state <= swdrv_pkg::ST_DRIVE;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        swdrv_pkg::ST_DRIVE, swdrv_pkg::ST_MBB_DROP: begin
          // Hold the pulse the full latch time, then release
          if (timer >= 32'(HOLD_CYCLES - 1)) begin
            timer <= 32'h0;
            drive_act <= 6'h00;
            cur_sel <= new_sel;
            state <= swdrv_pkg::ST_IDLE;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        swdrv_pkg::ST_MBB_BOTH: begin
          if (timer >= 32'(HOLD_CYCLES - 1)) begin
            timer <= 32'h0;
            drive_act <= new_sel;
            state <= swdrv_pkg::ST_MBB_DROP;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        swdrv_pkg::ST_OPEN_GAP: begin
          if (timer >= 32'(swdrv_pkg::SETTLE_CYC - 1)) begin
            timer <= 32'h0;
            open_act <= 1'b1;
            state <= swdrv_pkg::ST_OPEN_ALL;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        swdrv_pkg::ST_OPEN_ALL: begin
          if (timer >= 32'(HOLD_CYCLES - 1)) begin
            timer <= 32'h0;
            open_act <= 1'b0;
            cur_sel <= 6'h00;
            new_sel <= 6'h00;
            state <= swdrv_pkg::ST_IDLE;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        default: begin
          state <= swdrv_pkg::ST_IDLE;
          drive_act <= 6'h00;
          open_act <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // Pins and status
  // ********************************************************
  // Inactive level depends on variant: low-active pins idle high
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DRIVE <= ACTIVE_HIGH ? 6'h00 : 6'h3f;
      OPEN_ALL <= ~ACTIVE_HIGH;
    end else begin
      DRIVE <= ACTIVE_HIGH ? drive_act : ~drive_act;
      OPEN_ALL <= ACTIVE_HIGH ? open_act : ~open_act;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REQ_READY <= 1'b0;
      DONE <= 1'b0;
      FAULT <= 1'b0;
      PATH_STATE <= 6'h00;
    end else begin
      REQ_READY <= (state == swdrv_pkg::ST_IDLE) && !REQ_VALID;
      PATH_STATE <= IND_CLOSED & VALID_MASK;
      DONE <= 1'b0;
      FAULT <= 1'b0;
      // Completion trusts the indicators, not the drive lines
      if ((state == swdrv_pkg::ST_DRIVE || state == swdrv_pkg::ST_MBB_DROP)
          && timer >= 32'(HOLD_CYCLES - 1)) begin
        DONE <= ((IND_CLOSED & VALID_MASK) == new_sel);
        FAULT <= ((IND_CLOSED & VALID_MASK) != new_sel);
      end
      if (state == swdrv_pkg::ST_OPEN_ALL && timer >= 32'(HOLD_CYCLES - 1)) begin
        DONE <= ((IND_CLOSED & VALID_MASK) == 6'h00);
        FAULT <= ((IND_CLOSED & VALID_MASK) != 6'h00);
      end
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  property p_break_first;
    @(posedge CLK) disable iff (!RST_N)
    state == swdrv_pkg::ST_BREAK |-> drive_act == 6'h00;
  endproperty
  a_break_first: assert property (p_break_first)
    else $error("drive active during break gap");

  property p_open_alone;
    @(posedge CLK) disable iff (!RST_N)
    open_act |-> drive_act == 6'h00;
  endproperty
  a_open_alone: assert property (p_open_alone)
    else $error("open-all with drive active");

  property p_no_open_variant;
    @(posedge CLK) disable iff (!RST_N)
    !HAS_OPEN_ALL |-> !open_act;
  endproperty
  a_no_open_variant: assert property (p_no_open_variant)
    else $error("open-all used on variant without it");

  property p_unused_pos;
    @(posedge CLK) disable iff (!RST_N)
    (drive_act & ~VALID_MASK) == 6'h00;
  endproperty
  a_unused_pos: assert property (p_unused_pos)
    else $error("unused position driven");

  property p_single_bbm;
    @(posedge CLK) disable iff (!RST_N)
    state == swdrv_pkg::ST_DRIVE |-> $onehot0(drive_act);
  endproperty
  a_single_bbm: assert property (p_single_bbm)
    else $error("several paths driven in break-before-make");

  property p_mbb_drop;
    @(posedge CLK) disable iff (!RST_N)
    state == swdrv_pkg::ST_MBB_BOTH && timer == 32'(HOLD_CYCLES - 1)
    |=> drive_act == new_sel && state == swdrv_pkg::ST_MBB_DROP;
  endproperty
  a_mbb_drop: assert property (p_mbb_drop)
    else $error("old path not released after overlap");

  property p_mbb_both;
    @(posedge CLK) disable iff (!RST_N)
    state == swdrv_pkg::ST_MBB_BOTH |-> (drive_act & new_sel) == new_sel;
  endproperty
  a_mbb_both: assert property (p_mbb_both)
    else $error("new path not driven during overlap");

  property p_hold_len;
    @(posedge CLK) disable iff (!RST_N)
    $rose(state == swdrv_pkg::ST_DRIVE)
    |-> (state == swdrv_pkg::ST_DRIVE && drive_act != 6'h00)[*2];
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("drive pulse cut short");

  property p_pin_level;
    @(posedge CLK) disable iff (!RST_N)
    DRIVE == (ACTIVE_HIGH ? $past(drive_act) : ~$past(drive_act));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("drive pin level wrong");

  property p_done_ind;
    @(posedge CLK) disable iff (!RST_N)
    DONE && $past(state) != swdrv_pkg::ST_OPEN_ALL
    |-> $past(IND_CLOSED & VALID_MASK) == $past(new_sel);
  endproperty
  a_done_ind: assert property (p_done_ind)
    else $error("done without matching indicator");

  c_bbm: cover property (@(posedge CLK) disable iff (!RST_N)
    state == swdrv_pkg::ST_BREAK ##1 state == swdrv_pkg::ST_BREAK);
  c_mbb: cover property (@(posedge CLK) disable iff (!RST_N)
    state == swdrv_pkg::ST_MBB_DROP);
  c_open: cover property (@(posedge CLK) disable iff (!RST_N) open_act);
  c_done: cover property (@(posedge CLK) disable iff (!RST_N) DONE);

endmodule // swdrv_ctrl

// *** swdrv_pkg.sv ***
// Package of constants for the multiport switch path driver.
// Assumes a 25 MHz system clock; the hold time derives from CLK_NS.
package swdrv_pkg;
  localparam int CLK_NS = 40;
  localparam int HOLD_MS = 15;
  // Least hold, rounded up to whole cycles
  localparam int HOLD_CYC = (HOLD_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = 2;
  localparam int MAX_PATHS = 6;
  localparam logic [5:0] SP4T_MASK = 6'h36;
  localparam logic [5:0] SP6T_MASK = 6'h3f;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BREAK = 3'b001,
    ST_DRIVE = 3'b010,
    ST_MBB_BOTH = 3'b011,
    ST_MBB_DROP = 3'b100,
    ST_OPEN_GAP = 3'b101,
    ST_OPEN_ALL = 3'b110
  } state_t;
endpackage : swdrv_pkg

// *** swdrv_dev_model.sv ***
// Behavioural model of the latching multiport switch.
// Assumes active-low drive pins, sampled on clk.
module swdrv_dev_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] drive_n,
  input wire logic open_all_n,
  input wire logic jam,
  input wire logic [3:0] lat,
  output logic [5:0] ind_closed
);
  // ****
  // Position
  // ****
  logic [5:0] act;
  logic [3:0] cnt;
  assign act = ~drive_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      ind_closed <= 6'h00;
    end else if (!open_all_n) begin
      ind_closed <= 6'h00;
    end else if (act == 6'h00 || jam) begin
      // Latched: no current, position kept
      cnt <= 4'h0;
    end else if (cnt < lat) begin
      ind_closed <= ind_closed & act;
      cnt <= cnt + 4'h1;
    end else begin
      ind_closed <= act;
    end
  end
endmodule // swdrv_dev_model

// *** swdrv_ctrl_bench.sv ***
// Self-checking bench for the switch path controller.
// Assumes the device model closes a path inside the hold time.
module swdrv_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 8;
  localparam int BBM = swdrv_pkg::SETTLE_CYC + HOLD;
  // ****
  // Stimulus and checks
  // ****
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [2:0] req_path = 3'h0;
  logic req_mbb = 1'b0;
  logic req_open_all = 1'b0;
  logic jam = 1'b0;
  logic [3:0] lat = 4'h1;
  logic [5:0] ind, drive, state;
  logic oa, done, fault, rdy, oa4;
  logic [5:0] ind4, drive4;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  swdrv_ctrl #(.HOLD_CYCLES(HOLD)) i_dut (
    .CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_PATH(req_path),
    .REQ_MBB(req_mbb), .REQ_OPEN_ALL(req_open_all), .IND_CLOSED(ind),
    .REQ_READY(rdy), .DRIVE(drive), .OPEN_ALL(oa), .DONE(done),
    .FAULT(fault), .PATH_STATE(state));
  swdrv_dev_model i_dev (
    .clk(clk), .rst_n(rst_n), .drive_n(drive), .open_all_n(oa),
    .jam(jam), .lat(lat), .ind_closed(ind));
  // Four-throw, high-active, no open-all variant on the same requests
  swdrv_ctrl #(.HOLD_CYCLES(HOLD), .SIX_THROW(1'b0), .HAS_OPEN_ALL(1'b0),
    .ACTIVE_HIGH(1'b1)) i_dut4 (
    .CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_PATH(req_path),
    .REQ_MBB(req_mbb), .REQ_OPEN_ALL(req_open_all), .IND_CLOSED(ind4),
    .REQ_READY(), .DRIVE(drive4), .OPEN_ALL(oa4), .DONE(), .FAULT(),
    .PATH_STATE());
  swdrv_dev_model i_dev4 (
    .clk(clk), .rst_n(rst_n), .drive_n(~drive4), .open_all_n(~oa4),
    .jam(jam), .lat(lat), .ind_closed(ind4));
  task automatic check(input string what, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %0h seen %0h", what, e, s);
    end
  endtask
  task automatic run(input string nm, input logic [2:0] p,
    input logic m, input logic o, input logic [1:0] ans,
    input logic [6:0] seen_exp, input logic [6:0] seen4_exp, input int hold,
    input int cyc, input logic [5:0] st);
    int n;
    int h;
    logic [6:0] seen;
    logic [6:0] seen4;
    n = 0;
    h = 0;
    seen = 7'h00;
    seen4 = 7'h00;
    @(posedge clk);
    #1;
    check("ready", rdy, 1'b1);
    {req_path, req_mbb, req_open_all, req_valid} = {p, m, o, 1'b1};
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    // Bounded wait; an ignored request ends at the bound
    while (!(done === 1'b1 || fault === 1'b1) && n < 40) begin
      @(posedge clk);
      #1;
      n++;
      seen = seen | {~oa, ~drive};
      seen4 = seen4 | {oa4, drive4};
      if ({~oa, ~drive} != 7'h00) h++;
    end
    check("answer", {done, fault}, ans);
    check("cycles", n, cyc);
    check("drives", seen, seen_exp);
    check("variant", seen4, seen4_exp);
    check("hold", h, hold);
    check("state", state, st);
    $display("done %s", nm);
  endtask
  task automatic t_first();
    run("first", 3'h2, 1'b0, 1'b0, 2'h2, 7'h04, 7'h04, HOLD, BBM,
      6'h04);
  endtask
  task automatic t_mbb();
    run("mbb", 3'h5, 1'b1, 1'b0, 2'h2, 7'h24, 7'h24, 2 * HOLD, 2 * HOLD,
      6'h20);
  endtask
  task automatic t_change();
    lat = 4'h3;
    run("change", 3'h0, 1'b0, 1'b0, 2'h2, 7'h01, 7'h00, HOLD, BBM,
      6'h01);
  endtask
  task automatic t_open();
    run("open", 3'h1, 1'b0, 1'b1, 2'h2, 7'h40, 7'h00, HOLD, BBM,
      6'h00);
  endtask
  task automatic t_bad();
    run("bad", 3'h6, 1'b0, 1'b0, 2'h0, 7'h00, 7'h00, 0, 40,
      6'h00);
  endtask
  task automatic t_fault();
    jam = 1'b1;
    run("fault", 3'h3, 1'b0, 1'b0, 2'h1, 7'h08, 7'h00, HOLD, BBM,
      6'h00);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Cuts a hang short; the tests need some 110 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_first();
    t_mbb();
    t_change();
    t_open();
    t_bad();
    t_fault();
    end_of_test();
  end
endmodule // swdrv_ctrl_bench
